// file: verilog/channel_integrity_response.sv
`timescale 1ns/10ps
`default_nettype none
// ********************************************************************
// Channel 5-8 control-signal integrity response frame
// ********************************************************************
module channel_integrity_response
    import integrity_response_pkg::*;
#(
    parameter int CHANNELS = NUM_CHANNELS
)
(
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire logic                external_reset_pin_n,
    input  wire logic                commandValid,
    input  wire logic [3:0]          commandCode,
    input  wire logic                commandReadOnly,
    input  wire logic [CHANNELS-1:0] drainMonitor,
    input  wire logic [CHANNELS-1:0] serial_on_command,
    input  wire logic [CHANNELS-1:0] parallel_input_pin,
    input  wire logic [CHANNELS-1:0] input_source_select,
    input  wire logic [CHANNELS-1:0] highSideSelect,
    input  wire logic [CHANNELS-1:0] pchannelSelect,
    input  wire logic [CHANNELS-1:0] pull_up_source,
    input  wire logic [CHANNELS-1:0] pull_down_source,
    output logic [31:0]              responseFrame,
    output logic                     responseValid,
    output logic [CHANNELS-1:0]      integrityFault
);

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Even-parity flag: one when the count of ones is even.
    function automatic logic evenOnes(input logic [30:0] bits);
        evenOnes = ~(^bits);
    endfunction : evenOnes

    // A defined code is on, off or three-state; anything else is a fault.
    function automatic logic badCode(input logic [2:0] c, input logic p);
        if (p) begin
            badCode = !(c == SRC_PFET_ON || c == SRC_OFF_PU_PFET
                        || c == SRC_TRISTATE);
        end else begin
            badCode = !(c == SRC_NFET_ON || c == SRC_OFF_PD_NFET
                        || c == SRC_TRISTATE);
        end
    endfunction : badCode

    // ****************************************************************
    // Per-channel live status
    // ****************************************************************
    logic [CHANNELS-1:0]   liveDrain;
    logic [CHANNELS-1:0]   liveCommand;
    logic [3*CHANNELS-1:0] liveSource;
    logic [CHANNELS-1:0]   liveFault;

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_channel
            logic pch;
            // P-channel only exists on a high-side driver.
            assign pch = pchannelSelect[ch] & highSideSelect[ch];
            source_status_encoder u_encoder (
                .pchannel   (pch),
                .pullUpOn   (pull_up_source[ch]),
                .pullDownOn (pull_down_source[ch]),
                .code       (liveSource[3*ch +: 3])
            );                                                   // [R11]
            // Comparator level is reported raw; its meaning follows the
            // side the channel drives.
            assign liveDrain[ch] = drainMonitor[ch];             // [R9]
            // Parallel pin, active low, used when source select is set.
            assign liveCommand[ch] = input_source_select[ch]
                ? (serial_on_command[ch] & ~parallel_input_pin[ch])
                : serial_on_command[ch];                         // [R10]
            assign liveFault[ch] = badCode(liveSource[3*ch +: 3], pch); // [R4]
        end
    endgenerate

    // ****************************************************************
    // Frame state
    // ****************************************************************
    frame_state_type       state;
    frame_state_type       next_state;
    logic                  readOnly;
    logic                  next_readOnly;
    logic [31:0]           next_responseFrame;
    logic                  next_responseValid;
    logic [CHANNELS-1:0]   next_integrityFault;
    logic [30:0]           body;
    logic                  softReset;

    // The external reset pin restores fields just like power-on.
    assign softReset = ~external_reset_pin_n;

    // Snapshot is taken only on command 12; configuration is untouched.
    always_comb begin
        next_state          = state;
        next_readOnly       = readOnly;
        next_responseFrame  = responseFrame;
        next_responseValid  = 1'b0;
        next_integrityFault = liveFault;
        body                = {RESPONSE_CODE, readOnly, FIXED_PATTERN,
                               liveDrain, liveCommand, liveSource};
        case (state)
            IDLE_ST: begin
                if (commandValid && commandCode == COMMAND_CODE) begin
                    next_readOnly = commandReadOnly;             // [R7]
                    next_state    = LOAD_ST;
                end
            end
            LOAD_ST: begin
                // One cycle later, so the echoed selector is in the frame.
                next_responseFrame  = {body, evenOnes(body)};   // [R5] [R6] [R8] [R12]
                next_responseValid  = 1'b1;                     // [R12]
                next_state          = IDLE_ST;
            end
            default: begin
                next_state = IDLE_ST;
            end
        endcase
        if (softReset) begin
            next_state          = IDLE_ST;
            next_readOnly       = 1'b1;                          // [R7]
            next_responseFrame  = FRAME_RESET;                   // [R12]
            next_responseValid  = 1'b0;
        end
    end

    // Registers only; reset values are fixed constants.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state          <= IDLE_ST;
            readOnly       <= 1'b1;                              // [R7]
            responseFrame  <= FRAME_RESET;                       // [R12]
            responseValid  <= 1'b0;
            integrityFault <= '0;
        end else begin
            state          <= next_state;
            readOnly       <= next_readOnly;
            responseFrame  <= next_responseFrame;
            responseValid  <= next_responseValid;
            integrityFault <= next_integrityFault;
        end
    end

endmodule : channel_integrity_response
`default_nettype wire

// file: verilog/integrity_response_pkg.sv
//
// Behaviour
// (R1) PFET high-side: pull-down on reports 100.
// (R2) PFET high-side: pull-up 010, both off 000.
// (R3) NFET: pull-down 010, pull-up 001, off 000.
// (R4) Other codes flag compromised control integrity.
// (R5) Bit 0 is one when other ones even.
// (R6) Bits 31:28 carry response code 1100.
// (R7) Bit 27 echoes read/write selector, resets one.
// (R8) Bits 26:21 carry fixed pattern 010101.
// (R9) Bits 20:17 drain monitors ch8..5, reset 1111.
// (R10) Bits 16:13 commanded state ch8..5, reset 0000.
// (R11) Bits 12:1 hold four 3-bit source codes.
// (R12) Whole frame returned after command 12, reset 0xCABE0001.
package integrity_response_pkg;

    // ****************************************************************
    // Frame layout and reset values
    // ****************************************************************
    localparam int          NUM_CHANNELS     = 4;
    localparam int          CODE_MSB         = 31;
    localparam int          CODE_LSB         = 28;
    localparam int          RW_BIT           = 27;
    localparam int          PATTERN_MSB      = 26;
    localparam int          PATTERN_LSB      = 21;
    localparam int          DRAIN_LSB        = 17;
    localparam int          COMMAND_LSB      = 13;
    localparam int          SOURCE_LSB       = 1;
    localparam int          PARITY_BIT       = 0;
    localparam logic [3:0]  RESPONSE_CODE    = 4'hc;
    localparam logic [3:0]  COMMAND_CODE     = 4'hc;
    localparam logic [5:0]  FIXED_PATTERN    = 6'h15;
    localparam logic [3:0]  DRAIN_RESET      = 4'hf;
    localparam logic [3:0]  COMMAND_RESET    = 4'h0;
    localparam logic [31:0] FRAME_RESET      = 32'hcabe0001;

    // ****************************************************************
    // Gate current-source codes
    // ****************************************************************
    localparam logic [2:0]  SRC_PFET_ON      = 3'h4;
    localparam logic [2:0]  SRC_OFF_PD_NFET  = 3'h2;
    localparam logic [2:0]  SRC_OFF_PU_PFET  = 3'h2;
    localparam logic [2:0]  SRC_NFET_ON      = 3'h1;
    localparam logic [2:0]  SRC_TRISTATE     = 3'h0;

    // Frame builder states.
    typedef enum logic [1:0] {
        IDLE_ST  = 2'b01,
        LOAD_ST  = 2'b10
    } frame_state_type;

endpackage : integrity_response_pkg

// file: verilog/source_status_encoder.sv
`timescale 1ns/10ps
`default_nettype none
// ********************************************************************
// Per-channel gate current-source encoder
// ********************************************************************
module source_status_encoder
    import integrity_response_pkg::*;
(
    input  wire logic       pchannel,
    input  wire logic       pullUpOn,
    input  wire logic       pullDownOn,
    output logic [2:0]      code
);

    // Code depends on transistor type; both sources on has no legal code
    // and is reported as 111 so the host sees the compromise.
    always_comb begin
        if (pullUpOn && pullDownOn) begin
            code = 3'h7;                                    // [R4]
        end else if (pullDownOn) begin
            code = pchannel ? SRC_PFET_ON : SRC_OFF_PD_NFET; // [R1] [R3]
        end else if (pullUpOn) begin
            code = pchannel ? SRC_OFF_PU_PFET : SRC_NFET_ON; // [R2] [R3]
        end else begin
            code = SRC_TRISTATE;                            // [R2] [R3]
        end
    end

endmodule : source_status_encoder
`default_nettype wire

// file: dv/channel_integrity_response_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ********************************************************************
// Port-level checks of the integrity response frame
// ********************************************************************
module channel_integrity_response_checker #(parameter int CHANNELS = 4) (
    input wire logic                clk_sys,
    input wire logic                rst,
    input wire logic                external_reset_pin_n,
    input wire logic                commandValid,
    input wire logic [3:0]          commandCode,
    input wire logic                commandReadOnly,
    input wire logic [CHANNELS-1:0] drainMonitor,
    input wire logic [CHANNELS-1:0] serial_on_command,
    input wire logic [CHANNELS-1:0] parallel_input_pin,
    input wire logic [CHANNELS-1:0] input_source_select,
    input wire logic [CHANNELS-1:0] highSideSelect,
    input wire logic [CHANNELS-1:0] pchannelSelect,
    input wire logic [CHANNELS-1:0] pull_up_source,
    input wire logic [CHANNELS-1:0] pull_down_source,
    input wire logic [31:0]         responseFrame,
    input wire logic                responseValid,
    input wire logic [CHANNELS-1:0] integrityFault
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // A snapshot request is a strobe carrying command twelve.
    wire logic take = commandValid && commandCode == 4'hc
                      && external_reset_pin_n;
    a_answer_two_cycles: assert property (take |-> ##2 responseValid)
        else $error("No frame two cycles after a snapshot request.");
    a_valid_one_pulse: assert property (responseValid |=> !responseValid)
        else $error("Frame strobe lasted more than one cycle.");
    a_no_spurious: assert property (responseValid |-> $past(take, 2))
        else $error("Frame strobe without a snapshot request.");
    a_code_field: assert property (responseValid |-> responseFrame[31:28] == 4'hc)
        else $error("Response code field is wrong.");
    a_rw_echo: assert property (take |-> ##2 responseFrame[27] == $past(commandReadOnly, 2))
        else $error("Read selector echo is wrong.");
    a_fixed_pattern: assert property (responseValid |-> responseFrame[26:21] == 6'h15)
        else $error("Check pattern field is wrong.");
    a_parity_even: assert property (responseValid |-> responseFrame[0] == ~^responseFrame[31:1])
        else $error("Parity bit is wrong.");
    a_pin_reset_frame: assert property (!external_reset_pin_n |=> responseFrame == 32'hcabe0001)
        else $error("Pin reset did not restore the frame.");
    a_both_on_fault: assert property (pull_up_source[0] && pull_down_source[0] |=> integrityFault[0])
        else $error("Both sources on without a fault flag.");
    a_nfet_off_clean: assert property (!highSideSelect[0] && pull_down_source[0] && !pull_up_source[0] |=> !integrityFault[0])
        else $error("Valid pull-down code flagged as fault.");
    c_snapshot: cover property (take ##2 responseValid);
    c_back_to_back: cover property (take ##2 take);
    c_pin_reset: cover property (!external_reset_pin_n);
endmodule : channel_integrity_response_checker
`default_nettype wire

// file: dv/host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ********************************************************************
// Host side: issues serial commands toward the response block
// ********************************************************************
module host_model (
    input  wire logic clk_sys,
    output logic      commandValid,
    output logic [3:0] commandCode,
    output logic      commandReadOnly
);
    // One-cycle strobe; afterwards the lines show the inverse so a stale
    // code can never pass for a fresh one.
    task automatic send(input logic [3:0] code, input logic ro);
        @(posedge clk_sys);
        commandValid <= 1'b1;
        commandCode <= code;
        commandReadOnly <= ro;
        @(posedge clk_sys);
        commandValid <= 1'b0;
        commandCode <= ~code;
        commandReadOnly <= ~ro;
    endtask : send
    // Idle until the first request.
    initial begin
        commandValid = 1'b0;
        commandCode = 4'h0;
        commandReadOnly = 1'b1;
    end
endmodule : host_model
`default_nettype wire

// file: dv/channel_integrity_response_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ********************************************************************
// Self-checking bench for the integrity response frame
// ********************************************************************
module channel_integrity_response_tb;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        external_reset_pin_n = 1'b1;
    logic        commandValid, commandReadOnly, responseValid;
    logic [3:0]  commandCode, integrityFault, drainMonitor, serial_on_command;
    logic [3:0]  parallel_input_pin, input_source_select, highSideSelect;
    logic [3:0]  pchannelSelect, pull_up_source, pull_down_source;
    logic [31:0] responseFrame;
    logic [35:0] notes[$];
    int          errors = 0;
    int          checked = 0;
    // Half period of the 250 MHz clock.
    always #2 clk_sys = ~clk_sys;
    host_model host (.clk_sys, .commandValid, .commandCode, .commandReadOnly);
    channel_integrity_response #(.CHANNELS(4)) DUT (.clk_sys, .rst,
        .external_reset_pin_n, .commandValid, .commandCode, .commandReadOnly,
        .drainMonitor, .serial_on_command, .parallel_input_pin,
        .input_source_select, .highSideSelect, .pchannelSelect,
        .pull_up_source, .pull_down_source, .responseFrame, .responseValid,
        .integrityFault);
    task automatic check(input string what, input logic [35:0] exp, got);
        checked++;
        if (exp !== got) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    // Expected source code; both sources on is the only undefined case.
    function automatic logic [2:0] srcCode(input int i);
        if (pull_up_source[i] && pull_down_source[i]) return 3'h7;
        if (highSideSelect[i] && pchannelSelect[i])
            return pull_down_source[i] ? 3'h4 : {1'b0, pull_up_source[i], 1'b0};
        return pull_down_source[i] ? 3'h2 : {2'b00, pull_up_source[i]};
    endfunction : srcCode
    // Note the expected frame and fault flags, then send the command.
    task automatic command(input logic [3:0] code, input logic ro, input int gap);
        logic [31:0] f;
        f[31:1] = {4'hc, ro, 6'h15, drainMonitor, serial_on_command
                   & ~(input_source_select & parallel_input_pin),
                   srcCode(3), srcCode(2), srcCode(1), srcCode(0)};
        f[0] = ~^f[31:1];
        if (code == 4'hc) notes.push_back({f, pull_up_source & pull_down_source});
        host.send(code, ro);
        repeat (gap) @(posedge clk_sys);
    endtask : command
    // Inputs change together at an edge and settle before use.
    task automatic shuffle;
        @(posedge clk_sys);
        {drainMonitor, serial_on_command, parallel_input_pin} <= 12'($urandom);
        {input_source_select, highSideSelect, pchannelSelect} <= 12'($urandom);
        {pull_up_source, pull_down_source} <= 8'($urandom);
        @(negedge clk_sys);
    endtask : shuffle
    // Each frame strobe takes the oldest note; none left reads as unknown.
    always @(posedge clk_sys)
        if (responseValid === 1'b1)
            check("frame", notes.size() ? notes.pop_front() : 36'hx, {responseFrame, integrityFault});
    initial begin
        int i;
        {drainMonitor, serial_on_command, parallel_input_pin} = 12'h000;
        {input_source_select, highSideSelect, pchannelSelect} = 12'h000;
        {pull_up_source, pull_down_source} = 8'h00;
        void'($urandom(32'h94d9));
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        check("reset", {32'hcabe0001, 4'h0}, {responseFrame, integrityFault});
        for (i = 0; i < 300; i++) begin
            shuffle;
            command(($urandom % 3) ? 4'hc : 4'($urandom), 1'($urandom), 0);
            command(4'hc, 1'($urandom), 2);
            if (i % 50 == 7) begin
                command(4'hc, 1'b0, 2);
                external_reset_pin_n <= 1'b0;
                @(posedge clk_sys);
                external_reset_pin_n <= 1'b1;
                @(negedge clk_sys);
                check("pin reset", 36'hcabe00010, {responseFrame, 4'h0});
            end
            for (int n = 0; n < 8 && notes.size() != 0; n++) @(negedge clk_sys);
            if (notes.size() != 0) begin
                errors++;
                tally_and_finish;
            end
        end
        tally_and_finish;
    end
endmodule : channel_integrity_response_tb
bind channel_integrity_response channel_integrity_response_checker
    #(.CHANNELS(CHANNELS)) chk (.clk_sys, .rst, .external_reset_pin_n,
    .commandValid, .commandCode, .commandReadOnly, .drainMonitor,
    .serial_on_command, .parallel_input_pin, .input_source_select,
    .highSideSelect, .pchannelSelect, .pull_up_source, .pull_down_source,
    .responseFrame, .responseValid, .integrityFault);
`default_nettype wire
